// File: flash_host_pkg.sv
/*
  Constants, types and timing for the host controller of a dual-bank
  parallel flash. Assumes a 200 MHz mclk and a word-mode (x16) device.
*/
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SETUP_NS = 10;
  localparam int T_WE_PULSE_NS = 40;
  localparam int T_HOLD_NS = 10;
  localparam int T_ACCESS_NS = 80;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_RESET_RECOVER_NS = 50;

  function automatic logic [7:0] cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction : cyc_up

  localparam logic [7:0] SETUP_CYC = cyc_up(T_SETUP_NS);
  localparam logic [7:0] PULSE_CYC = cyc_up(T_WE_PULSE_NS);
  localparam logic [7:0] HOLD_CYC = cyc_up(T_HOLD_NS);
  localparam logic [7:0] ACCESS_CYC = cyc_up(T_ACCESS_NS);
  localparam logic [7:0] SETTLE_CYC = 8'h03;
  localparam logic [7:0] RST_PULSE_CYC = cyc_up(T_RESET_PULSE_NS);
  localparam logic [7:0] RST_RECOVER_CYC = cyc_up(T_RESET_RECOVER_NS);

  // ----------------------------------------------------------------
  // Command words and addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 20'h00001;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 20'h00002;
  localparam logic [ADDR_W-1:0] BANK1_BASE = 20'h80000;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h0001;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0002;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h0003;
  localparam logic [DATA_W-1:0] CMD_AUTOSEL = 16'h0004;
  localparam logic [DATA_W-1:0] CMD_SEC_ENTER = 16'h0005;
  localparam logic [DATA_W-1:0] CMD_SEC_EXIT_A = 16'h0006;
  localparam logic [DATA_W-1:0] CMD_SEC_EXIT_B = 16'h0007;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h0008;
  localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0009;

  // ----------------------------------------------------------------
  // Autoselect and query map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MFR_ID = 20'h00000;
  localparam logic [ADDR_W-1:0] OFS_DEV_ID = 20'h00001;
  localparam logic [ADDR_W-1:0] OFS_PROTECT = 20'h00002;
  localparam logic [DATA_W-1:0] PROTECTED_VAL = 16'h0001;
  localparam logic [ADDR_W-1:0] QRY_PRI_ADDR = 20'h00040;
  localparam logic [ADDR_W-1:0] QRY_BANK2_ADDR = 20'h0004a;
  localparam logic [ADDR_W-1:0] QRY_BOOT_ADDR = 20'h0004f;
  localparam int EXCEED_BIT = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_WRITE = 4'h1,
    OP_RESET = 4'h2,
    OP_AUTOSEL = 4'h3,
    OP_PROTECT_READ = 4'h4,
    OP_SEC_ENTER = 4'h5,
    OP_SEC_EXIT = 4'h6,
    OP_SUSPEND = 4'h7,
    OP_RESUME = 4'h8,
    OP_HW_RESET = 4'h9
  } op_t;

  typedef enum logic [1:0] {
    MODE_READ = 2'h0,
    MODE_AUTOSEL = 2'h1,
    MODE_SUSP_READ = 2'h2,
    MODE_BUSY = 2'h3
  } bank_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic last;
  } step_t;

endpackage : flash_host_pkg

// File: bus_cycle_if.sv
/*
  Carrier between the sequencer and the bus cycle engine.
  Assumes both ends run on mclk.
*/
interface bus_cycle_if;
  logic start;
  logic is_write;
  logic [flash_host_pkg::ADDR_W-1:0] addr;
  logic [flash_host_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [flash_host_pkg::DATA_W-1:0] rdata;

  modport engine(input start, is_write, addr, wdata, output done, rdata);
  modport sequencer(output start, is_write, addr, wdata, input done, rdata);
endinterface : bus_cycle_if

// File: flash_bus_cycle.sv
/*
  One read or write cycle on the flash pins, each pin from a flop.
  Assumes start is pulsed only while the engine is idle.
*/
module flash_bus_cycle (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Sequencer side
  bus_cycle_if.engine cyc,
  // Flash pins
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [flash_host_pkg::ADDR_W-1:0] addr,
  output logic [flash_host_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_in
);

  typedef enum logic [2:0] {
    C_IDLE = 3'b000, C_SETUP = 3'b001, C_STROBE = 3'b011,
    C_HOLD = 3'b010, C_RWAIT = 3'b110, C_SETTLE = 3'b111
  } cyc_state_t;

  cyc_state_t state, next_state;
  logic write, next_write;
  logic [7:0] cnt, next_cnt;
  logic next_ce_n, next_we_n, next_oe_n, next_dq_oe, next_done;
  logic [flash_host_pkg::ADDR_W-1:0] next_addr;
  logic [flash_host_pkg::DATA_W-1:0] next_dq_out, next_rdata;
  logic [flash_host_pkg::DATA_W-1:0] s1, s2, s3;

  always_comb begin
    next_state = state;
    next_write = write;
    next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : cnt;
    next_ce_n = ce_n;
    next_we_n = we_n;
    next_oe_n = oe_n;
    next_addr = addr;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_done = 1'b0;
    next_rdata = cyc.rdata;
    unique case (state)
      C_IDLE: begin
        if (cyc.start) begin
          next_write = cyc.is_write;
          next_addr = cyc.addr;
          next_dq_out = cyc.wdata;
          next_dq_oe = cyc.is_write;
          next_ce_n = 1'b0;
          next_cnt = flash_host_pkg::SETUP_CYC;
          next_state = C_SETUP;
        end
      end
      C_SETUP: begin
        if (cnt == 8'h00) begin
          if (write) begin
            // Select already low, so the strobe fall is the later edge
            next_we_n = 1'b0;
            next_cnt = flash_host_pkg::PULSE_CYC;
            next_state = C_STROBE;
          end else begin
            next_oe_n = 1'b0;
            next_cnt = flash_host_pkg::ACCESS_CYC;
            next_state = C_RWAIT;
          end
        end
      end
      C_STROBE: begin
        if (cnt == 8'h00) begin
          // Strobe rises before select: data taken here, still driven
          next_we_n = 1'b1;
          next_cnt = flash_host_pkg::HOLD_CYC;
          next_state = C_HOLD;
        end
      end
      C_HOLD: begin
        if (cnt == 8'h00) begin
          next_ce_n = 1'b1;
          next_dq_oe = 1'b0;
          next_done = 1'b1;
          next_state = C_IDLE;
        end
      end
      C_RWAIT: begin
        if (cnt == 8'h00) begin
          next_cnt = flash_host_pkg::SETTLE_CYC;
          next_state = C_SETTLE;
        end
      end
      C_SETTLE: begin
        // Late stages must agree before the word is trusted
        if (cnt == 8'h00 && s2 == s3) begin
          next_rdata = s3;
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          next_done = 1'b1;
          next_state = C_IDLE;
        end
      end
      default: next_state = C_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    s1 <= dq_in;
    s2 <= s1;
    s3 <= s2;
    if (!reset_n) begin
      state <= C_IDLE;
      write <= 1'b0;
      cnt <= 8'h00;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      state <= next_state;
      write <= next_write;
      cnt <= next_cnt;
      ce_n <= next_ce_n;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      addr <= next_addr;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      cyc.done <= next_done;
      cyc.rdata <= next_rdata;
    end
  end

endmodule : flash_bus_cycle

// File: flash_host_ctrl.sv
/*
  Host controller for a dual-bank parallel flash: turns user operations
  into command sequences and mirrors each bank's mode.
  Assumes bank_busy comes from logic on mclk; dq_in is asynchronous.
*/
module flash_host_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // User operations
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic op_bank,
  input wire logic [flash_host_pkg::ADDR_W-1:0] op_addr,
  input wire logic [flash_host_pkg::DATA_W-1:0] op_data,
  output logic op_ready,
  output logic op_done,
  output logic op_error,
  output logic [flash_host_pkg::DATA_W-1:0] op_rdata,
  // Device state
  input wire logic [1:0] bank_busy,
  output logic [1:0] bank0_mode,
  output logic [1:0] bank1_mode,
  output logic secure_active,
  // Flash pins
  output logic flash_reset_n,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [flash_host_pkg::ADDR_W-1:0] addr,
  output logic [flash_host_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_in
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_WAIT = 2'b01, S_HWRST = 2'b11, S_RECOVER = 2'b10
  } seq_state_t;

  bus_cycle_if cyc ();

  flash_bus_cycle engine (
    .mclk(mclk),
    .reset_n(reset_n),
    .cyc(cyc),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n),
    .addr(addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .dq_in(dq_in)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [flash_host_pkg::ADDR_W-1:0] bank_base(
      input logic b);
    return b ? flash_host_pkg::BANK1_BASE : '0;
  endfunction : bank_base

  function automatic logic is_read(input logic [3:0] o);
    return o == flash_host_pkg::OP_READ || o == flash_host_pkg::OP_PROTECT_READ;
  endfunction : is_read

  function automatic flash_host_pkg::step_t seq_step(
      input logic [3:0] o, input logic [1:0] n, input logic b,
      input logic [flash_host_pkg::ADDR_W-1:0] a,
      input logic [flash_host_pkg::DATA_W-1:0] d);
    flash_host_pkg::step_t s;
    s.addr = a;
    s.data = d;
    s.last = 1'b1;
    unique case (o)
      flash_host_pkg::OP_RESET: s.data = flash_host_pkg::CMD_RESET;
      flash_host_pkg::OP_PROTECT_READ:
        s.addr = a | flash_host_pkg::OFS_PROTECT;
      flash_host_pkg::OP_SUSPEND: begin
        s.addr = bank_base(b);
        s.data = flash_host_pkg::CMD_SUSPEND;
      end
      flash_host_pkg::OP_RESUME: begin
        s.addr = bank_base(b);
        s.data = flash_host_pkg::CMD_RESUME;
      end
      flash_host_pkg::OP_AUTOSEL, flash_host_pkg::OP_SEC_ENTER,
      flash_host_pkg::OP_SEC_EXIT: begin
        s.last = 1'b0;
        if (n == 2'd0) begin
          s.addr = flash_host_pkg::UNLOCK1_ADDR;
          s.data = flash_host_pkg::UNLOCK1_DATA;
        end else if (n == 2'd1) begin
          s.addr = flash_host_pkg::UNLOCK2_ADDR;
          s.data = flash_host_pkg::UNLOCK2_DATA;
        end else if (n == 2'd2) begin
          s.last = o != flash_host_pkg::OP_SEC_EXIT;
          s.addr = flash_host_pkg::UNLOCK1_ADDR;
          if (o == flash_host_pkg::OP_AUTOSEL) begin
            s.addr = bank_base(b) | flash_host_pkg::UNLOCK1_ADDR;
            s.data = flash_host_pkg::CMD_AUTOSEL;
          end else if (o == flash_host_pkg::OP_SEC_ENTER) begin
            s.data = flash_host_pkg::CMD_SEC_ENTER;
          end else begin
            s.data = flash_host_pkg::CMD_SEC_EXIT_A;
          end
        end else begin
          s.last = 1'b1;
          s.addr = '0;
          s.data = flash_host_pkg::CMD_SEC_EXIT_B;
        end
      end
      default: ;
    endcase
    return s;
  endfunction : seq_step

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  seq_state_t state, next_state;
  logic [3:0] op, next_op;
  logic [1:0] step, next_step;
  logic bank, next_bank;
  logic [flash_host_pkg::ADDR_W-1:0] uaddr, next_uaddr;
  logic [flash_host_pkg::DATA_W-1:0] udata, next_udata;
  logic [7:0] cnt, next_cnt;
  logic [1:0] mode [2];
  logic [1:0] next_mode [2];
  logic [1:0] suspended, next_suspended;
  logic pend_reset, next_pend_reset;
  logic next_secure, next_reset_pin, next_ready, next_done, next_error;
  logic [flash_host_pkg::DATA_W-1:0] next_rdata;
  logic next_start, next_is_write;
  logic [flash_host_pkg::ADDR_W-1:0] next_caddr;
  logic [flash_host_pkg::DATA_W-1:0] next_cwdata;
  flash_host_pkg::step_t cur;
  logic legal;

  assign cur = seq_step(op, step, bank, uaddr, udata);

  always_comb begin
    flash_host_pkg::step_t first;
    flash_host_pkg::step_t upcoming;
    first = seq_step(op_code, 2'd0, op_bank, op_addr, op_data);
    upcoming = seq_step(op, step + 2'd1, bank, uaddr, udata);
    next_state = state;
    next_op = op;
    next_step = step;
    next_bank = bank;
    next_uaddr = uaddr;
    next_udata = udata;
    next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : cnt;
    next_mode = mode;
    next_suspended = suspended;
    next_pend_reset = pend_reset;
    next_secure = secure_active;
    next_reset_pin = flash_reset_n;
    next_done = 1'b0;
    next_error = 1'b0;
    next_rdata = op_rdata;
    next_start = 1'b0;
    next_is_write = cyc.is_write;
    next_caddr = cyc.addr;
    next_cwdata = cyc.wdata;
    // Autoselect only from a read mode with neither bank working
    legal = op_code != flash_host_pkg::OP_AUTOSEL
         || ((mode[op_bank] == flash_host_pkg::MODE_READ
           || mode[op_bank] == flash_host_pkg::MODE_SUSP_READ)
          && bank_busy == 2'b00);
    unique case (state)
      S_IDLE: begin
        if (pend_reset) begin
          // Exceeded-limit seen: clear the bank with a reset command
          next_pend_reset = 1'b0;
          next_op = flash_host_pkg::OP_RESET;
          next_step = 2'd0;
          next_start = 1'b1;
          next_is_write = 1'b1;
          next_caddr = uaddr;
          next_cwdata = flash_host_pkg::CMD_RESET;
          next_state = S_WAIT;
        end else if (op_valid && op_ready) begin
          next_op = op_code;
          next_bank = op_bank;
          next_uaddr = op_addr;
          next_udata = op_data;
          next_step = 2'd0;
          if (!legal) begin
            next_error = 1'b1;
          end else if (op_code == flash_host_pkg::OP_HW_RESET) begin
            next_reset_pin = 1'b0;
            next_cnt = flash_host_pkg::RST_PULSE_CYC;
            next_state = S_HWRST;
          end else begin
            next_start = 1'b1;
            next_is_write = !is_read(op_code);
            next_caddr = first.addr;
            next_cwdata = first.data;
            next_state = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (cyc.done && !cur.last) begin
          next_step = step + 2'd1;
          next_start = 1'b1;
          next_caddr = upcoming.addr;
          next_cwdata = upcoming.data;
        end else if (cyc.done) begin
          next_done = 1'b1;
          next_state = S_IDLE;
          if (is_read(op)) begin
            next_rdata = cyc.rdata;
            if (bank_busy[bank] && cyc.rdata[flash_host_pkg::EXCEED_BIT]) begin
              next_pend_reset = 1'b1;
            end
          end
          unique case (op)
            flash_host_pkg::OP_RESET: begin
              // Both banks drop back; a suspended bank keeps its suspend
              for (int b = 0; b < 2; b++) begin
                next_mode[b] = suspended[b] ? flash_host_pkg::MODE_SUSP_READ
                                            : flash_host_pkg::MODE_READ;
              end
            end
            flash_host_pkg::OP_AUTOSEL:
              next_mode[bank] = flash_host_pkg::MODE_AUTOSEL;
            flash_host_pkg::OP_SUSPEND: begin
              next_suspended[bank] = 1'b1;
              next_mode[bank] = flash_host_pkg::MODE_SUSP_READ;
            end
            flash_host_pkg::OP_RESUME: begin
              next_suspended[bank] = 1'b0;
              next_mode[bank] = flash_host_pkg::MODE_READ;
            end
            flash_host_pkg::OP_SEC_ENTER: next_secure = 1'b1;
            flash_host_pkg::OP_SEC_EXIT: next_secure = 1'b0;
            default: ;
          endcase
        end
      end
      S_HWRST: begin
        if (cnt == 8'h00) begin
          next_reset_pin = 1'b1;
          next_cnt = flash_host_pkg::RST_RECOVER_CYC;
          next_state = S_RECOVER;
        end
      end
      S_RECOVER: begin
        if (cnt == 8'h00) begin
          // Pin reset ends any suspend, autoselect and secure access
          next_mode[0] = flash_host_pkg::MODE_READ;
          next_mode[1] = flash_host_pkg::MODE_READ;
          next_suspended = 2'b00;
          next_secure = 1'b0;
          next_done = 1'b1;
          next_state = S_IDLE;
        end
      end
    endcase
    next_ready = next_state == S_IDLE && !next_pend_reset;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= S_IDLE;
      op <= '0;
      step <= '0;
      bank <= 1'b0;
      uaddr <= '0;
      udata <= '0;
      cnt <= 8'h00;
      mode[0] <= flash_host_pkg::MODE_READ;
      mode[1] <= flash_host_pkg::MODE_READ;
      suspended <= 2'b00;
      pend_reset <= 1'b0;
      secure_active <= 1'b0;
      flash_reset_n <= 1'b1;
      op_ready <= 1'b0;
      op_done <= 1'b0;
      op_error <= 1'b0;
      op_rdata <= '0;
      cyc.start <= 1'b0;
      cyc.is_write <= 1'b0;
      cyc.addr <= '0;
      cyc.wdata <= '0;
      bank0_mode <= flash_host_pkg::MODE_READ;
      bank1_mode <= flash_host_pkg::MODE_READ;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      bank <= next_bank;
      uaddr <= next_uaddr;
      udata <= next_udata;
      cnt <= next_cnt;
      mode <= next_mode;
      suspended <= next_suspended;
      pend_reset <= next_pend_reset;
      secure_active <= next_secure;
      flash_reset_n <= next_reset_pin;
      op_ready <= next_ready;
      op_done <= next_done;
      op_error <= next_error;
      op_rdata <= next_rdata;
      cyc.start <= next_start;
      cyc.is_write <= next_is_write;
      cyc.addr <= next_caddr;
      cyc.wdata <= next_cwdata;
      // Busy input overrides the mirrored mode for display
      bank0_mode <= bank_busy[0] ? flash_host_pkg::MODE_BUSY : next_mode[0];
      bank1_mode <= bank_busy[1] ? flash_host_pkg::MODE_BUSY : next_mode[1];
    end
  end

endmodule : flash_host_ctrl

// File: flash_dev_model.sv
/* Behavioural dual-bank flash device on the host controller pins.
   Assumes strobes come from flops and the host never drives on reads. */
module flash_dev_model #(
  parameter logic [15:0] MFR_ID = 16'h00a7, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h00b3 // Arbitrary value
) (
  // Device pins
  input wire logic rst_n,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode [2] = '{2'h0, 2'h0};
  logic [1:0] susp = 2'h0;
  logic sec = 1'b0;
  logic [2:0] cyc = 3'h0;
  logic [19:0] la = 20'h0;
  logic [15:0] rd;
  logic [15:0] last = 16'h0;
  // --------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) la = addr;
  always @(posedge we_n or posedge ce_n or negedge rst_n) begin
    if (!rst_n) begin
      mode = '{2'h0, 2'h0};
      sec = 1'b0;
      cyc = 3'h0;
    end else if (we_n ^ ce_n) begin
      if (dq_out == flash_host_pkg::CMD_RESET) begin
        mode = '{susp[0] ? 2'h2 : 2'h0, susp[1] ? 2'h2 : 2'h0};
        cyc = 3'h0;
      end else if (cyc == 3'h0 && la == flash_host_pkg::UNLOCK1_ADDR &&
          dq_out == flash_host_pkg::UNLOCK1_DATA) cyc = 3'h1;
      else if (cyc == 3'h1 && la == flash_host_pkg::UNLOCK2_ADDR &&
          dq_out == flash_host_pkg::UNLOCK2_DATA) cyc = 3'h2;
      else if (cyc == 3'h2 && dq_out == flash_host_pkg::CMD_SEC_EXIT_A)
        cyc = 3'h3;
      else begin
        if (cyc == 3'h2 && dq_out == flash_host_pkg::CMD_AUTOSEL)
          mode[la[19]] = 2'h1;
        if (cyc == 3'h2 && dq_out == flash_host_pkg::CMD_SEC_ENTER)
          sec = 1'b1;
        if (cyc == 3'h3 && dq_out == flash_host_pkg::CMD_SEC_EXIT_B)
          sec = 1'b0;
        if (dq_out == flash_host_pkg::CMD_SUSPEND) begin
          susp[la[19]] = 1'b1;
          mode[la[19]] = 2'h2;
        end
        if (dq_out == flash_host_pkg::CMD_RESUME) begin
          susp[la[19]] = 1'b0;
          mode[la[19]] = 2'h0;
        end
        // A broken sequence simply starts over
        cyc = 3'h0;
      end
    end
  end
  always_comb begin
    if (sec) rd = addr[15:0] ^ 16'hc3a5;
    else if (mode[addr[19]] != 2'h1) rd = addr[15:0] ^ 16'h3c5a;
    else if (addr[7:0] == 8'h00) rd = MFR_ID;
    else if (addr[7:0] == 8'h01) rd = DEV_ID;
    else if (addr[7:0] == 8'h02) rd = {15'h0, addr[12]};
    else rd = addr[15:0] ^ 16'h3c5a;
  end
  // Released bus shows the inverse so a stale value cannot pass
  always @(ce_n, oe_n, rd) if (!ce_n && !oe_n) last = rd;
  assign dq_in = (!ce_n && !oe_n) ? rd : ~last;
endmodule : flash_dev_model

// File: flash_host_props.sv
/* Checker on the host controller ports.
   Assumes one mclk domain and a synchronous reset_n. */
module flash_host_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // User side
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic op_error,
  // Device state
  input wire logic [1:0] bank_busy,
  input wire logic [1:0] bank0_mode,
  input wire logic [1:0] bank1_mode,
  input wire logic secure_active,
  // Flash pins
  input wire logic flash_reset_n,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic take;
  logic [3:0] last_op;
  logic [2:0] wcnt;
  assign take = op_valid && op_ready;
  // --------------------------------------------------------------
  // Write strobes counted per operation
  // --------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (take) begin
      last_op <= op_code;
      wcnt <= 3'h0;
    end else if ($fell(we_n)) begin
      wcnt <= wcnt + 3'h1;
    end
  end
  addr_edge_a: assert property (
    $fell(we_n) |-> !ce_n && !$past(ce_n)) else $error("we_n fell first");
  data_edge_a: assert property (
    $rose(we_n) |-> !ce_n ##1 !ce_n) else $error("ce_n rose first");
  pulse_hold_a: assert property (
    !we_n && !$past(we_n) |-> $stable(addr) && $stable(dq_out) && dq_oe)
    else $error("bus moved in pulse");
  asel_refuse_a: assert property (
    take && op_code == flash_host_pkg::OP_AUTOSEL && bank_busy != 2'h0
    |=> op_error && ce_n ##1 ce_n) else $error("autoselect not refused");
  asel_writes_a: assert property (
    op_done && last_op == flash_host_pkg::OP_AUTOSEL |-> wcnt == 3'h3)
    else $error("autoselect write count");
  exit_writes_a: assert property (
    op_done && last_op == flash_host_pkg::OP_SEC_EXIT |-> wcnt == 3'h4)
    else $error("secure exit write count");
  hw_reset_a: assert property (
    $fell(flash_reset_n) |-> ##[100:120] (op_done && !secure_active))
    else $error("reset pin cycle");
  busy_mirror_a: assert property (
    $past(bank_busy[0]) && $past(reset_n) && $past(reset_n, 2)
    |-> bank0_mode == flash_host_pkg::MODE_BUSY) else $error("busy mirror");
  reset_cmd_a: assert property (
    take && op_code == flash_host_pkg::OP_RESET |-> ##[2:40] (op_done &&
    bank0_mode != 2'h1 && bank1_mode != 2'h1)) else $error("reset command");
endmodule : flash_host_props
bind flash_host_ctrl flash_host_props u_flash_host_props (
  .mclk, .reset_n, .op_valid, .op_code, .op_ready, .op_done, .op_error,
  .bank_busy, .bank0_mode, .bank1_mode, .secure_active, .flash_reset_n,
  .ce_n, .we_n, .addr, .dq_out, .dq_oe);

// File: testbench.sv
/* Self-checking bench: host controller against the device model.
   Assumes the design files and the model are compiled first. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MFR = 16'h00a7; // Arbitrary value
  localparam logic [15:0] DEV = 16'h00b3; // Arbitrary value
  localparam logic [19:0] B1 = flash_host_pkg::BANK1_BASE;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid = 1'b0;
  logic op_bank = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [19:0] op_addr = 20'h0;
  logic [15:0] op_data = 16'h0;
  logic [1:0] bank_busy = 2'h0;
  logic op_ready, op_done, op_error, secure_active, flash_reset_n, err;
  logic ce_n, we_n, oe_n, dq_oe;
  logic [1:0] bank0_mode, bank1_mode;
  logic [19:0] addr;
  logic [15:0] op_rdata, dq_out, dq_in;
  logic [31:0] r;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 32'h7e62;
  always #2.5 mclk = ~mclk;
  flash_host_ctrl u_flash_host_ctrl (.mclk, .reset_n, .op_valid, .op_code,
    .op_bank, .op_addr, .op_data, .op_ready, .op_done, .op_error, .op_rdata,
    .bank_busy, .bank0_mode, .bank1_mode, .secure_active, .flash_reset_n,
    .ce_n, .we_n, .oe_n, .addr, .dq_out, .dq_oe, .dq_in);
  flash_dev_model #(.MFR_ID(MFR), .DEV_ID(DEV)) u_flash_dev_model (
    .rst_n(flash_reset_n), .ce_n, .we_n, .oe_n, .addr, .dq_out, .dq_in);
  function automatic logic [15:0] arr(input logic [19:0] a);
    return a[15:0] ^ 16'h3c5a;
  endfunction : arr
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // --------------------------------------------------------------
  // One user operation, entered and left at a falling edge
  // --------------------------------------------------------------
  task automatic do_op(input logic [3:0] c, input logic [19:0] a);
    while (op_ready !== 1'b1) @(negedge mclk);
    r = $random(seed);
    op_valid = 1'b1;
    op_code = c;
    op_bank = a[19];
    op_addr = a;
    op_data = r[15:0];
    @(negedge mclk);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && op_error !== 1'b1) @(negedge mclk);
    err = op_error;
    @(negedge mclk);
  endtask : do_op
  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    do_op(flash_host_pkg::OP_READ, a);
    check(op_rdata, e);
  endtask : rd
  initial begin
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      rd(r[19:0], arr(r[19:0]));
    end
    do_op(flash_host_pkg::OP_AUTOSEL, 20'h00000);
    check(bank0_mode, flash_host_pkg::MODE_AUTOSEL);
    rd(20'h00000, MFR);
    rd(20'h00001, DEV);
    do_op(flash_host_pkg::OP_PROTECT_READ, 20'h01000);
    check(op_rdata, 16'h0001);
    rd(20'h02002, 16'h0000);
    rd(B1 | 20'h00005, arr(B1 | 20'h00005));
    r = $random(seed);
    do_op(flash_host_pkg::OP_RESET, r[19:0]);
    check(bank0_mode, flash_host_pkg::MODE_READ);
    rd(20'h00001, arr(20'h00001));
    do_op(flash_host_pkg::OP_SUSPEND, B1);
    do_op(flash_host_pkg::OP_AUTOSEL, B1);
    rd(B1, MFR);
    do_op(flash_host_pkg::OP_RESET, B1);
    check(bank1_mode, flash_host_pkg::MODE_SUSP_READ);
    rd(B1, arr(B1));
    do_op(flash_host_pkg::OP_RESUME, B1);
    do_op(flash_host_pkg::OP_AUTOSEL, B1);
    bank_busy = 2'h2;
    rd(B1 | 20'h00020, arr(B1 | 20'h00020));
    bank_busy = 2'h1;
    do_op(flash_host_pkg::OP_AUTOSEL, B1);
    check(err, 1'b1);
    check(bank0_mode, flash_host_pkg::MODE_BUSY);
    bank_busy = 2'h0;
    rd(B1, arr(B1));
    do_op(flash_host_pkg::OP_SEC_ENTER, 20'h00000);
    check(secure_active, 1'b1);
    rd(20'h00123, 16'h0123 ^ 16'hc3a5);
    do_op(flash_host_pkg::OP_SEC_EXIT, 20'h00000);
    rd(20'h00123, arr(20'h00123));
    do_op(flash_host_pkg::OP_SEC_ENTER, 20'h00000);
    do_op(flash_host_pkg::OP_HW_RESET, 20'h00000);
    check(secure_active, 1'b0);
    rd(20'h00124, arr(20'h00124));
    end_of_test();
  end
  // Whole sequence needs well under 20 us
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule : testbench
